// file: cres_pkg.sv
// Purpose: Constants for the processor RAM error syndrome log
// Assumes: One core clock, asynchronous active-low reset
// Notes:   Register is 64 bits, reached by paired coprocessor transfers
// Contract
// RULE1: Fatal bit set on first aborting error; code ignores the abort of a coinciding first error that is not selected
// RULE2: Valid bit set on first error, sticky
// RULE3: Mismatch count cleared first, then counts mismatches
// RULE4: Repeat count cleared first, then counts matches
// RULE5: RAM identifier code of first error recorded
// RULE6: Bank or way of first error captured
// RULE7: Index of first error captured
// RULE8: Flags and counters reset to zero
// RULE9: Same-RAM same-cycle errors count once
// RULE10: Coinciding first errors: capture one, count one
// RULE11: Coinciding mismatches add exactly one
// RULE12: Whole register read and written by pair transfers
// RULE13: Any write clears whole register
// RULE14: Access only at privilege level one or above
// RULE15: Each RAM strobes error with location and abort
package cres_pkg;
  localparam int          NUM_RAMS     = 6;
  localparam int          RAM_IDENTIFIER_W      = 7;
  localparam int          WAY_W        = 5;
  localparam int          INDEX_W      = 18;
  localparam int          CNT_W        = 8;
  localparam int          FATAL_BIT    = 63;
  localparam int          OTHER_LSB    = 40;
  localparam int          REPEAT_LSB   = 32;
  localparam int          VALID_BIT    = 31;
  localparam int          RAM_IDENTIFIER_LSB    = 24;
  localparam int          WAY_LSB      = 18;
  localparam int          INDEX_LSB    = 0;
  localparam logic [63:0] SYNDROME_RST = 64'h0000_0000_0000_0000;
  localparam logic [6:0]  RAM_IDENTIFIER_ITAG   = 7'h00;
  localparam logic [6:0]  RAM_IDENTIFIER_IDATA  = 7'h01;
  localparam logic [6:0]  RAM_IDENTIFIER_BTB    = 7'h02;
  localparam logic [6:0]  RAM_IDENTIFIER_DTAG   = 7'h08;
  localparam logic [6:0]  RAM_IDENTIFIER_DDATA  = 7'h09;
  localparam logic [6:0]  RAM_IDENTIFIER_TLB    = 7'h18;
endpackage : cres_pkg

// file: cres_sel.sv
// Purpose: Picks one error among coinciding RAM error strobes
// Assumes: Strobes are one-cycle pulses
// Notes:   Lowest-numbered RAM wins; the choice is free
`timescale 1ns/1ps
module cres_sel #(
  parameter int N  = 6,
  parameter int WW = 5,
  parameter int IW = 18
) (
  input  wire logic [N-1:0]    err_stb,
  input  wire logic [N*WW-1:0] err_way,
  input  wire logic [N*IW-1:0] err_index,
  output logic                 any_err,
  output logic [$clog2(N)-1:0] sel_id,
  output logic [WW-1:0]        sel_way,
  output logic [IW-1:0]        sel_index
);
  initial
  begin
    if (N < 2) $error("cres_sel needs at least two sources");
  end

  always_comb
  begin
    any_err   = |err_stb;
    sel_id    = '0;
    sel_way   = '0;
    sel_index = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (err_stb[i])
      begin
        sel_id    = ($clog2(N))'(i);
        sel_way   = err_way[i*WW +: WW];
        sel_index = err_index[i*IW +: IW];
      end
    end
  end
endmodule : cres_sel

// file: cres_log.sv
// Purpose: RAM error syndrome log, 64-bit register with counters
// Assumes: Error strobes are synchronous, one per RAM per cycle
// Notes:   Write of any data clears the whole register
`timescale 1ns/1ps
module cres_log
  import cres_pkg::*;
#(
  parameter int N = cres_pkg::NUM_RAMS
) (
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  input  wire logic [N-1:0]               err_stb,
  input  wire logic [N-1:0]               err_abort,
  input  wire logic [N*cres_pkg::WAY_W-1:0]   err_way,
  input  wire logic [N*cres_pkg::INDEX_W-1:0] err_index,
  input  wire logic                       cp_read,
  input  wire logic                       cp_write,
  input  wire logic                       cp_priv,
  input  wire logic [63:0]                cp_wdata,
  output logic [63:0]                     cp_rdata,
  output logic                            cp_fault
);
  import cres_pkg::*;

  initial
  begin
    if (N != NUM_RAMS) $error("cres_log: identifier table has six RAMs");
  end

  localparam logic [6:0] RAM_IDENTIFIER_TAB [NUM_RAMS] = '{RAM_IDENTIFIER_ITAG, RAM_IDENTIFIER_IDATA,
      RAM_IDENTIFIER_BTB, RAM_IDENTIFIER_DTAG, RAM_IDENTIFIER_DDATA, RAM_IDENTIFIER_TLB};

  logic                   fatal_reg, fatal_next;
  logic                   valid_reg, valid_next;
  logic [CNT_W-1:0]       other_reg, other_next;
  logic [CNT_W-1:0]       repeat_reg, repeat_next;
  logic [RAM_IDENTIFIER_W-1:0]     ram_identifier_reg, ram_identifier_next;
  logic [WAY_W-1:0]       way_reg, way_next;
  logic [INDEX_W-1:0]     index_reg, index_next;
  logic [63:0]            rdata_reg, rdata_next;
  logic                   fault_reg, fault_next;
  logic                   any_err;
  logic [$clog2(N)-1:0]   sel_id;
  logic [WAY_W-1:0]       sel_way;
  logic [INDEX_W-1:0]     sel_index;
  logic [N-1:0]           match;
  logic                   wr_ok;
  logic [63:0]            syndrome;

  // One strobe per RAM already folds same-cycle errors in that RAM
  cres_sel #(.N(N), .WW(WAY_W), .IW(INDEX_W)) u_sel (  // RULE9 RULE10
    .err_stb   (err_stb),
    .err_way   (err_way),
    .err_index (err_index),
    .any_err   (any_err),
    .sel_id    (sel_id),
    .sel_way   (sel_way),
    .sel_index (sel_index)
  );

  assign wr_ok = cp_write && cp_priv;  // RULE14

  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      match[i] = err_stb[i] && RAM_IDENTIFIER_TAB[i] == ram_identifier_reg
                 && err_way[i*WAY_W +: WAY_W] == way_reg
                 && err_index[i*INDEX_W +: INDEX_W] == index_reg;
    end
  end

  always_comb
  begin
    syndrome = SYNDROME_RST;
    syndrome[FATAL_BIT]                  = fatal_reg;
    syndrome[OTHER_LSB +: CNT_W]         = other_reg;
    syndrome[REPEAT_LSB +: CNT_W]        = repeat_reg;
    syndrome[VALID_BIT]                  = valid_reg;
    syndrome[RAM_IDENTIFIER_LSB +: RAM_IDENTIFIER_W]       = ram_identifier_reg;
    syndrome[WAY_LSB +: WAY_W]           = way_reg;
    syndrome[INDEX_LSB +: INDEX_W]       = index_reg;
  end

  always_comb
  begin
    fatal_next  = fatal_reg;
    valid_next  = valid_reg;
    other_next  = other_reg;
    repeat_next = repeat_reg;
    ram_identifier_next  = ram_identifier_reg;
    way_next    = way_reg;
    index_next  = index_reg;
    if (wr_ok)
    begin
      // Write wins; an error in that same cycle is lost by design
      fatal_next  = 1'b0;  // RULE13
      valid_next  = 1'b0;
      other_next  = '0;
      repeat_next = '0;
      ram_identifier_next  = '0;
      way_next    = '0;
      index_next  = '0;
    end
    else if (any_err && !valid_reg)
    begin
      valid_next  = 1'b1;  // RULE2
      fatal_next  = err_abort[sel_id];  // RULE1
      ram_identifier_next  = RAM_IDENTIFIER_TAB[sel_id];  // RULE5
      way_next    = sel_way;  // RULE6
      index_next  = sel_index;  // RULE7
      other_next  = (|(err_stb & ~(N'(1) << sel_id))) ? CNT_W'(1) : '0;  // RULE3 RULE10
      repeat_next = '0;  // RULE4
    end
    else if (any_err)
    begin
      if (|match)
        repeat_next = repeat_reg + CNT_W'(1);  // RULE4
      if (|(err_stb & ~match))
        other_next = other_reg + CNT_W'(1);  // RULE3 RULE11
      if (|(err_stb & err_abort))
        fatal_next = 1'b1;  // RULE1
    end
  end

  always_comb
  begin
    rdata_next = rdata_reg;
    fault_next = (cp_read || cp_write) && !cp_priv;  // RULE14
    if (cp_read && cp_priv)
      rdata_next = syndrome;  // RULE12
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fatal_reg  <= 1'b0;  // RULE8
      valid_reg  <= 1'b0;
      other_reg  <= '0;
      repeat_reg <= '0;
      ram_identifier_reg  <= '0;
      way_reg    <= '0;
      index_reg  <= '0;
      rdata_reg  <= SYNDROME_RST;
      fault_reg  <= 1'b0;
    end
    else
    begin
      fatal_reg  <= fatal_next;
      valid_reg  <= valid_next;
      other_reg  <= other_next;
      repeat_reg <= repeat_next;
      ram_identifier_reg  <= ram_identifier_next;
      way_reg    <= way_next;
      index_reg  <= index_next;
      rdata_reg  <= rdata_next;
      fault_reg  <= fault_next;
    end
  end

  assign cp_rdata = rdata_reg;
  assign cp_fault = fault_reg;

  valid_first_a: assert property (@(posedge clk) disable iff (!reset_n)  // RULE2
    !valid_reg && any_err && !wr_ok |=> valid_reg && repeat_reg == 8'h00)
    else $error("valid not set on first error");
  valid_sticky_a: assert property (@(posedge clk) disable iff (!reset_n)  // RULE2
    valid_reg && !wr_ok |=> valid_reg)
    else $error("valid dropped without write");
  write_clear_a: assert property (@(posedge clk) disable iff (!reset_n)  // RULE13
    wr_ok |=> syndrome == 64'h0)
    else $error("write did not clear register");
  fatal_first_a: assert property (@(posedge clk) disable iff (!reset_n)  // RULE1
    !valid_reg && any_err && !wr_ok |=> fatal_reg == $past(err_abort[sel_id]))
    else $error("fatal not taken from first error");
  ram_identifier_code_a: assert property (@(posedge clk) disable iff (!reset_n)  // RULE5
    !valid_reg && any_err && !wr_ok |=> ram_identifier_reg == RAM_IDENTIFIER_TAB[$past(sel_id)])
    else $error("wrong RAM identifier");
  repeat_inc_a: assert property (@(posedge clk) disable iff (!reset_n)  // RULE4
    valid_reg && |match && !wr_ok |=> repeat_reg == $past(repeat_reg) + 8'h01)
    else $error("repeat count wrong");
  other_one_a: assert property (@(posedge clk) disable iff (!reset_n)  // RULE11
    valid_reg && |(err_stb & ~match) && !wr_ok |=> other_reg == $past(other_reg) + 8'h01)
    else $error("mismatch count wrong");
  index_hold_a: assert property (@(posedge clk) disable iff (!reset_n)  // RULE7
    valid_reg && !wr_ok |=> $stable(index_reg) && $stable(way_reg))
    else $error("capture changed while valid");
  priv_fault_a: assert property (@(posedge clk) disable iff (!reset_n)  // RULE14
    cp_write && !cp_priv && valid_reg |=> valid_reg && cp_fault)
    else $error("unprivileged write acted");
  read_data_a: assert property (@(posedge clk) disable iff (!reset_n)  // RULE12
    cp_read && cp_priv |=> cp_rdata == $past(syndrome))
    else $error("read data wrong");
  fatal_sticky_a: assert property (@(posedge clk) disable iff (!reset_n)  // RULE1
    fatal_reg && !wr_ok |=> fatal_reg)
    else $error("fatal dropped without write");
  first_count_a: assert property (@(posedge clk) disable iff (!reset_n)  // RULE3
    !valid_reg && $countones(err_stb) == 1 && !wr_ok |=> other_reg == 8'h00)
    else $error("mismatch count not cleared on first error");
  coin_count_a: assert property (@(posedge clk) disable iff (!reset_n)  // RULE10
    !valid_reg && $countones(err_stb) > 1 && !wr_ok |=> other_reg == 8'h01)
    else $error("coinciding first errors not counted once");
  capture_loc_a: assert property (@(posedge clk) disable iff (!reset_n)  // RULE6 RULE7
    !valid_reg && any_err && !wr_ok
    |=> way_reg == $past(sel_way) && index_reg == $past(sel_index))
    else $error("first error location not captured");
  rdata_hold_a: assert property (@(posedge clk) disable iff (!reset_n)  // RULE14
    cp_read && !cp_priv |=> $stable(cp_rdata) && cp_fault)
    else $error("unprivileged read changed data");
  priv_ok_a: assert property (@(posedge clk) disable iff (!reset_n)  // RULE14
    (cp_read || cp_write) && cp_priv |=> !cp_fault)
    else $error("privileged access faulted");
  // No disable here: reset itself is what this one watches
  reset_zero_a: assert property (@(posedge clk)  // RULE8
    !reset_n |-> syndrome == 64'h0 && cp_rdata == 64'h0 && !cp_fault)
    else $error("state not zero in reset");

  first_err_c: cover property (@(posedge clk) disable iff (!reset_n)
    !valid_reg && any_err);
  repeat_c: cover property (@(posedge clk) disable iff (!reset_n)
    valid_reg && |match);
  multi_first_c: cover property (@(posedge clk) disable iff (!reset_n)
    !valid_reg && $countones(err_stb) > 1);
  clear_c: cover property (@(posedge clk) disable iff (!reset_n)
    valid_reg && wr_ok);
  late_fatal_c: cover property (@(posedge clk) disable iff (!reset_n)
    valid_reg && !fatal_reg && |(err_stb & err_abort));
endmodule : cres_log

// file: cres_ram_model.sv
// Purpose: RAM error detector model feeding the syndrome log
// Assumes: One strobe pulse per call, same location on all hit RAMs
// Notes:   Idle location lines go inverted so stale data never matches
`timescale 1ns/1ps
module cres_ram_model (
  input  wire logic    clk,
  output logic [5:0]   err_stb,
  output logic [5:0]   err_abort,
  output logic [29:0]  err_way,
  output logic [107:0] err_index
);
  initial
  begin
    err_stb   = '0;
    err_abort = '0;
    err_way   = '0;
    err_index = '0;
  end
  task automatic hit(input logic [5:0] m, input logic [5:0] a,
                     input logic [4:0] w, input logic [17:0] ix);
    @(posedge clk);
    #1;
    err_stb   = m;
    err_abort = a;
    err_way   = {6{w}};
    err_index = {6{ix}};
    @(posedge clk);
    #1;
    err_stb   = '0;
    err_abort = '0;
    err_way   = ~err_way;
    err_index = ~err_index;
  endtask : hit
endmodule : cres_ram_model

// file: tb_cres_log.sv
// Purpose: Self-checking bench for the RAM error syndrome log
// Assumes: Lowest-numbered RAM wins a same-cycle first error
// Notes:   Expected words built from field layout, not design output
`timescale 1ns/1ps
`define CHK(n, e, g) \
  compares++; \
  if ((g) !== (e)) \
  begin \
    fails++; \
    $display("mismatch %s exp %h got %h", n, e, g); \
  end
module tb_cres_log;
  import cres_pkg::*;
  logic          clk;
  logic          reset_n;
  logic          cp_read;
  logic          cp_write;
  logic          cp_priv;
  logic          cp_fault;
  logic [63:0]   cp_wdata;
  logic [63:0]   cp_rdata;
  logic [5:0]    stb;
  logic [5:0]    abt;
  logic [29:0]   way;
  logic [107:0]  idx;
  int            fails;
  int            compares;
  logic [6:0]    ids [6];
  logic [63:0]   held;

  cres_ram_model ram (.clk(clk), .err_stb(stb), .err_abort(abt), .err_way(way),
                      .err_index(idx));
  cres_log #(.N(6)) uut (.clk(clk), .reset_n(reset_n), .err_stb(stb), .err_abort(abt),
    .err_way(way), .err_index(idx), .cp_read(cp_read), .cp_write(cp_write),
    .cp_priv(cp_priv), .cp_wdata(cp_wdata), .cp_rdata(cp_rdata), .cp_fault(cp_fault));

  function automatic logic [63:0] mk(logic f, logic [7:0] o, logic [7:0] r,
                                     logic [6:0] id, logic [4:0] w, logic [17:0] ix);
    return {f, 15'h0000, o, r, 1'b1, id, 1'b0, w, ix};
  endfunction : mk

  task automatic acc(input logic r, input logic w, input logic p);
    @(posedge clk);
    #1;
    cp_read  = r;
    cp_write = w;
    cp_priv  = p;
    @(posedge clk);
    #1;
    cp_read  = 1'b0;
    cp_write = 1'b0;
  endtask : acc

  task automatic rd_chk(input string n, input logic [63:0] e);
    acc(1'b1, 1'b0, 1'b1);
    `CHK(n, e, cp_rdata)
  endtask : rd_chk

  task automatic sc_count;
    acc(1'b0, 1'b1, 1'b1);
    ram.hit(6'h08, 6'h08, 5'h02, 18'h00005);
    rd_chk("first", mk(1'b1, 8'h00, 8'h00, RAM_IDENTIFIER_DTAG, 5'h02, 18'h00005));
    ram.hit(6'h08, 6'h00, 5'h02, 18'h00005);
    ram.hit(6'h10, 6'h00, 5'h02, 18'h00005);
    // Match plus two mismatching RAMs in one cycle
    ram.hit(6'h0B, 6'h00, 5'h02, 18'h00005);
    rd_chk("counts", mk(1'b1, 8'h02, 8'h02, RAM_IDENTIFIER_DTAG, 5'h02, 18'h00005));
    acc(1'b0, 1'b1, 1'b1);
    rd_chk("clear", 64'h0000_0000_0000_0000);
  endtask : sc_count

  task automatic sc_coin;
    ram.hit(6'h28, 6'h00, 5'h07, 18'h3FFFF);
    held = mk(1'b0, 8'h01, 8'h00, RAM_IDENTIFIER_DTAG, 5'h07, 18'h3FFFF);
    rd_chk("coincide", held);
  endtask : sc_coin

  task automatic sc_priv;
    acc(1'b1, 1'b0, 1'b0);
    `CHK("fault", 1'b1, cp_fault)
    `CHK("rdata held", held, cp_rdata)
    acc(1'b0, 1'b1, 1'b0);
    rd_chk("no clear", held);
    `CHK("no fault", 1'b0, cp_fault)
  endtask : sc_priv

  task automatic sc_ids;
    for (int i = 0; i < 6; i++)
    begin
      acc(1'b0, 1'b1, 1'b1);
      ram.hit(6'(6'h01 << i), 6'h00, 5'(i), 18'(i));
      rd_chk("ram_identifier", mk(1'b0, 8'h00, 8'h00, ids[i], 5'(i), 18'(i)));
    end
  endtask : sc_ids

  task automatic sc_late;
    acc(1'b0, 1'b1, 1'b1);
    ram.hit(6'h01, 6'h00, 5'h1F, 18'h2AAAA);
    // Later aborting error from another RAM still raises fatal
    ram.hit(6'h02, 6'h02, 5'h1F, 18'h2AAAA);
    held = mk(1'b1, 8'h01, 8'h00, RAM_IDENTIFIER_ITAG, 5'h1F, 18'h2AAAA);
    rd_chk("late fatal", held);
    acc(1'b1, 1'b1, 1'b1);
    `CHK("read on write", held, cp_rdata)
    rd_chk("after write", 64'h0000_0000_0000_0000);
  endtask : sc_late

  task automatic sc_reset;
    ram.hit(6'h20, 6'h20, 5'h04, 18'h00100);
    rd_chk("before reset", mk(1'b1, 8'h00, 8'h00, RAM_IDENTIFIER_TLB, 5'h04, 18'h00100));
    @(posedge clk);
    #1;
    reset_n = 1'b0;
    @(posedge clk);
    #1;
    reset_n = 1'b1;
    `CHK("rdata reset", 64'h0000_0000_0000_0000, cp_rdata)
    `CHK("fault reset", 1'b0, cp_fault)
    rd_chk("state reset", 64'h0000_0000_0000_0000);
  endtask : sc_reset

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    #20000;
    fails++;
    summarize();
  end

  initial
  begin
    ids      = '{RAM_IDENTIFIER_ITAG, RAM_IDENTIFIER_IDATA, RAM_IDENTIFIER_BTB, RAM_IDENTIFIER_DTAG, RAM_IDENTIFIER_DDATA, RAM_IDENTIFIER_TLB};
    fails    = 0;
    compares = 0;
    reset_n  = 1'b0;
    cp_read  = 1'b0;
    cp_write = 1'b0;
    cp_priv  = 1'b0;
    cp_wdata = 64'hFFFF_FFFF_FFFF_FFFF;
    repeat (3) @(posedge clk);
    #1;
    reset_n = 1'b1;
    rd_chk("reset", 64'h0000_0000_0000_0000);
    sc_count();
    sc_coin();
    sc_priv();
    sc_ids();
    sc_late();
    sc_reset();
    summarize();
  end
endmodule : tb_cres_log
